// ==== hw/pwm_autoreload_timer.sv ====
// Eight-bit auto-reload PWM timer with capture, AXI4-Lite register slave.
`include "pwm_art_defs.svh"
module pwm_autoreload_timer
(
  input  wire logic                     clk_in,
  input  wire logic                     srst_in,
  input  wire logic [`AXI_ADDR_W-1:0]   s_axi_awaddr_in,
  input  wire logic                     s_axi_awvalid_in,
  output wire logic                     s_axi_awready_out,
  input  wire logic [`AXI_DATA_W-1:0]   s_axi_wdata_in,
  input  wire logic [3:0]               s_axi_wstrb_in,
  input  wire logic                     s_axi_wvalid_in,
  output wire logic                     s_axi_wready_out,
  output wire logic [1:0]               s_axi_bresp_out,
  output wire logic                     s_axi_bvalid_out,
  input  wire logic                     s_axi_bready_in,
  input  wire logic [`AXI_ADDR_W-1:0]   s_axi_araddr_in,
  input  wire logic                     s_axi_arvalid_in,
  output wire logic                     s_axi_arready_out,
  output wire logic [`AXI_DATA_W-1:0]   s_axi_rdata_out,
  output wire logic [1:0]               s_axi_rresp_out,
  output wire logic                     s_axi_rvalid_out,
  input  wire logic                     s_axi_rready_in,
  input  wire logic                     ext_clk_in,
  input  wire logic                     halt_in,
  input  wire logic [`NUM_CAP-1:0]      capture_input_in,
  output wire logic [`NUM_PWM-1:0]      pwm_out_out,
  output wire logic [`NUM_PWM-1:0]      pwm_out_en_n_out,
  output wire logic                     overflow_irq_out,
  output wire logic [`NUM_CAP-1:0]      capture_irq_out,
  output wire logic [`NUM_CAP-1:0]      capture_wake_out
);

  // Software visible state.
  logic [`NUM_PWM-1:0][7:0]   duty_cycle_reg_ff;
  pwm_art_pkg::reg8_t         pwm_output_control_ff;
  pwm_art_pkg::reg8_t         auto_reload_value_ff;
  pwm_art_pkg::clk_src_t      ext_clk_select_ff;
  logic [2:0]                 prescale_select_ff;
  logic                       counter_run_enable_ff;
  logic                       overflow_irq_en_ff;
  logic                       overflow_flag_ff;
  logic [`NUM_CAP-1:0]        capture_edge_select_ff;
  logic [`NUM_CAP-1:0]        capture_irq_en_ff;

  // Timer core state.
  pwm_art_pkg::reg8_t         cnt_ff;
  logic [`PSC_W-1:0]          psc_ff;
  logic [`NUM_PWM-1:0][7:0]   compare_shadow_ff;
  logic [`NUM_PWM-1:0]        raw_ff;
  logic [`NUM_PWM-1:0]        pwm_ff;
  logic                       ext_prev_ff;

  // Bus slave state.
  pwm_art_pkg::wr_state_t     wr_state_ff;
  logic                       aw_held_ff;
  logic                       w_held_ff;
  logic [`AXI_ADDR_W-1:0]     aw_addr_ff;
  pwm_art_pkg::reg8_t         w_data_ff;
  logic                       w_lane0_ff;
  logic [1:0]                 bresp_ff;
  logic                       rvalid_ff;
  logic [`AXI_DATA_W-1:0]     rdata_ff;
  logic [1:0]                 rresp_ff;

  // Write decode: a write happens once address and data are both held.
  logic [7:0]                 wr_idx;
  logic                       wr_fire;
  logic                       wr_mapped;
  logic                       wr_ok;
  logic                       wr_duty3;
  logic                       wr_duty2;
  logic                       wr_duty1;
  logic                       wr_duty0;
  logic                       wr_pwm_output_control;
  logic                       wr_csr;
  logic                       wr_car;
  logic                       wr_arr;
  logic                       wr_iccsr;
  logic                       force_reload;

  assign wr_idx    = aw_addr_ff[`ADDR_IDX_HI:`ADDR_IDX_LO];
  assign wr_fire   = (wr_state_ff == pwm_art_pkg::WR_COLLECT)
                     & aw_held_ff & w_held_ff;
  assign wr_mapped = (aw_addr_ff[`ADDR_TOP_HI:`ADDR_TOP_LO] == 2'b00)
                     & (wr_idx >= `IDX_DUTY3) & (wr_idx <= `IDX_ICR2);
  assign wr_ok     = wr_fire & wr_mapped & w_lane0_ff;
  assign wr_duty3  = wr_ok & (wr_idx == `IDX_DUTY3);
  assign wr_duty2  = wr_ok & (wr_idx == `IDX_DUTY2);
  assign wr_duty1  = wr_ok & (wr_idx == `IDX_DUTY1);
  assign wr_duty0  = wr_ok & (wr_idx == `IDX_DUTY0);
  assign wr_pwm_output_control  = wr_ok & (wr_idx == `IDX_PWM_OUTPUT_CONTROL);
  assign wr_csr    = wr_ok & (wr_idx == `IDX_CSR);
  assign wr_car    = wr_ok & (wr_idx == `IDX_CAR);
  assign wr_arr    = wr_ok & (wr_idx == `IDX_ARR);
  assign wr_iccsr  = wr_ok & (wr_idx == `IDX_ICCSR);
  // The reload bit acts as a one-shot and is never stored.
  assign force_reload = wr_csr & w_data_ff[`CSR_FORCE_RELOAD];

  // Read decode; the side effects of a read fire on its address handshake.
  logic [7:0]                 rd_idx;
  logic                       ar_fire;
  logic                       rd_mapped;
  logic                       rd_csr;
  logic [`NUM_CAP-1:0]        rd_icr;
  pwm_art_pkg::reg8_t         rd_csr_val;
  pwm_art_pkg::reg8_t         rd_iccsr_val;
  pwm_art_pkg::reg8_t         rd_val;

  assign rd_idx    = s_axi_araddr_in[`ADDR_IDX_HI:`ADDR_IDX_LO];
  assign ar_fire   = s_axi_arvalid_in & ~rvalid_ff;
  assign rd_mapped = (s_axi_araddr_in[`ADDR_TOP_HI:`ADDR_TOP_LO] == 2'b00)
                     & (rd_idx >= `IDX_DUTY3) & (rd_idx <= `IDX_ICR2);
  assign rd_csr    = ar_fire & rd_mapped & (rd_idx == `IDX_CSR);
  assign rd_icr[0] = ar_fire & rd_mapped & (rd_idx == `IDX_ICR1);
  assign rd_icr[1] = ar_fire & rd_mapped & (rd_idx == `IDX_ICR2);
  // The force reload position always reads back as zero.
  assign rd_csr_val = {ext_clk_select_ff, prescale_select_ff,
                       counter_run_enable_ff, 1'b0, overflow_irq_en_ff,
                       overflow_flag_ff};

  // Counter clocking: source select, prescaler taps and run gate.
  logic                       ext_rise;
  logic                       in_tick;
  logic                       psc_tick;
  logic [7:0]                 psc_div;
  logic [`PSC_W-1:0]          psc_mask;
  logic                       cnt_tick;
  logic                       overflow;

  // The external pin is sampled on the CPU clock, so it must run slower.
  assign ext_rise = ext_clk_in & ~ext_prev_ff;
  assign in_tick  = (ext_clk_select_ff == pwm_art_pkg::CLK_SRC_EXT)
                    ? ext_rise : 1'b1;
  assign psc_tick = in_tick & counter_run_enable_ff & ~halt_in;
  assign psc_div  = `CNT_ONE << prescale_select_ff;
  assign psc_mask = psc_div[`PSC_W-1:0] - `PSC_ONE;
  assign cnt_tick = psc_tick & ((psc_ff & psc_mask) == psc_mask);
  // Wrap from FFh; also counts external events in event mode.
  assign overflow = cnt_tick & (cnt_ff == `CNT_MAX);

  // Next counter and prescaler: software access wins over counting.
  pwm_art_pkg::reg8_t         nxt_cnt;
  logic [`PSC_W-1:0]          nxt_psc;
  logic [`NUM_PWM-1:0][7:0]   nxt_compare_shadow;
  logic [`NUM_PWM-1:0]        nxt_raw;
  logic [`NUM_PWM-1:0]        nxt_pwm;
  logic [`NUM_PWM-1:0]        out_en;
  logic [`NUM_PWM-1:0]        out_pol;

  assign nxt_cnt = wr_car       ? w_data_ff :
                   force_reload ? auto_reload_value_ff :
                   overflow     ? auto_reload_value_ff :
                   cnt_tick     ? cnt_ff + `CNT_ONE : cnt_ff;
  // Overflow leaves the prescaler counting on.
  assign nxt_psc = (wr_car | force_reload) ? `PSC_RST :
                   psc_tick ? psc_ff + `PSC_ONE : psc_ff;
  assign nxt_compare_shadow = overflow ? duty_cycle_reg_ff
                                       : compare_shadow_ff;
  assign out_en  = pwm_output_control_ff[`PWM_OUTPUT_CONTROL_OE_LO +: `NUM_PWM];
  assign out_pol = pwm_output_control_ff[`NUM_PWM-1:0];

  // Active phase runs from the reload point up to the compare value.
  always_comb
  begin
    for (int i = 0; i < `NUM_PWM; i++)
    begin
      nxt_raw[i] = (nxt_cnt <= nxt_compare_shadow[i]);
      nxt_pwm[i] = out_en[i] & (raw_ff[i] ^ out_pol[i]);
    end
  end

  // Capture channels.
  logic [`NUM_CAP-1:0]        cap_flag;
  logic [`NUM_CAP-1:0][7:0]   cap_value;

  for (genvar k = 0; k < `NUM_CAP; k++)
  begin : g_cap
    capture_if cap_bus ();
    assign cap_bus.pin      = capture_input_in[k];
    assign cap_bus.edge_sel = capture_edge_select_ff[k];
    assign cap_bus.irq_en   = capture_irq_en_ff[k];
    assign cap_bus.halt     = halt_in;
    assign cap_bus.count    = cnt_ff;
    assign cap_bus.rd_clear = rd_icr[k];
    assign cap_flag[k]      = cap_bus.flag;
    assign cap_value[k]     = cap_bus.value;
    assign capture_irq_out[k]  = cap_bus.irq;
    assign capture_wake_out[k] = cap_bus.wake;
    capture_channel u_chan
    (
      .clk_in  (clk_in),
      .srst_in (srst_in),
      .cap     (cap_bus.chan)
    );
  end

  assign rd_iccsr_val = {2'b00, capture_edge_select_ff, capture_irq_en_ff,
                         cap_flag};

  // Read data mux.
  always_comb
  begin
    case (rd_idx)
      `IDX_DUTY3: rd_val = duty_cycle_reg_ff[3];
      `IDX_DUTY2: rd_val = duty_cycle_reg_ff[2];
      `IDX_DUTY1: rd_val = duty_cycle_reg_ff[1];
      `IDX_DUTY0: rd_val = duty_cycle_reg_ff[0];
      `IDX_PWM_OUTPUT_CONTROL: rd_val = pwm_output_control_ff;
      `IDX_CSR:   rd_val = rd_csr_val;
      `IDX_CAR:   rd_val = cnt_ff;
      `IDX_ARR:   rd_val = auto_reload_value_ff;
      `IDX_ICCSR: rd_val = rd_iccsr_val;
      `IDX_ICR1:  rd_val = cap_value[0];
      `IDX_ICR2:  rd_val = cap_value[1];
      default:    rd_val = `REG_RST;
    endcase
  end

  // Software registers; only byte lane 0 of a word carries data.
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      duty_cycle_reg_ff      <= '0;
      pwm_output_control_ff  <= `REG_RST;
      auto_reload_value_ff   <= `REG_RST;
      ext_clk_select_ff      <= pwm_art_pkg::CLK_SRC_CPU;
      prescale_select_ff     <= 3'h0;
      counter_run_enable_ff  <= 1'b0;
      overflow_irq_en_ff     <= 1'b0;
      capture_edge_select_ff <= '0;
      capture_irq_en_ff      <= '0;
    end
    else
    begin
      if (wr_duty3) duty_cycle_reg_ff[3] <= w_data_ff;
      if (wr_duty2) duty_cycle_reg_ff[2] <= w_data_ff;
      if (wr_duty1) duty_cycle_reg_ff[1] <= w_data_ff;
      if (wr_duty0) duty_cycle_reg_ff[0] <= w_data_ff;
      if (wr_pwm_output_control) pwm_output_control_ff <= w_data_ff;
      if (wr_arr)   auto_reload_value_ff  <= w_data_ff;
      if (wr_csr)
      begin
        ext_clk_select_ff <= pwm_art_pkg::clk_src_t'(w_data_ff[`CSR_EXT_CLK_SELECT]);
        prescale_select_ff    <= w_data_ff[`CSR_CC_HI:`CSR_CC_LO];
        counter_run_enable_ff <= w_data_ff[`CSR_TCE];
        overflow_irq_en_ff    <= w_data_ff[`CSR_OIE];
      end
      if (wr_iccsr)
      begin
        capture_edge_select_ff <= w_data_ff[`ICC_CS_LO +: `NUM_CAP];
        capture_irq_en_ff      <= w_data_ff[`ICC_CIE_LO +: `NUM_CAP];
      end
    end
  end

  // Timer core; PWM levels freeze while the device halts.
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      cnt_ff            <= `REG_RST;
      psc_ff            <= `PSC_RST;
      compare_shadow_ff <= '0;
      raw_ff            <= '0;
      pwm_ff            <= '0;
      ext_prev_ff       <= 1'b0;
      overflow_flag_ff  <= 1'b0;
    end
    else
    begin
      cnt_ff            <= nxt_cnt;
      psc_ff            <= nxt_psc;
      compare_shadow_ff <= nxt_compare_shadow;
      ext_prev_ff       <= ext_clk_in;
      // A wrap in the same cycle as the clearing read is kept.
      overflow_flag_ff  <= overflow | (overflow_flag_ff & ~rd_csr);
      if (!halt_in)
      begin
        raw_ff <= nxt_raw;
        pwm_ff <= nxt_pwm;
      end
    end
  end

  assign pwm_out_out       = pwm_ff;
  assign pwm_out_en_n_out  = ~out_en;
  assign overflow_irq_out  = overflow_flag_ff & overflow_irq_en_ff;

  // Write channel: address and data are taken in either order.
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      wr_state_ff <= pwm_art_pkg::WR_COLLECT;
      aw_held_ff  <= 1'b0;
      w_held_ff   <= 1'b0;
      aw_addr_ff  <= '0;
      w_data_ff   <= `REG_RST;
      w_lane0_ff  <= 1'b0;
      bresp_ff    <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_in && !aw_held_ff)
      begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && !w_held_ff)
      begin
        w_held_ff  <= 1'b1;
        w_data_ff  <= s_axi_wdata_in[7:0];
        w_lane0_ff <= s_axi_wstrb_in[0];
      end
      case (wr_state_ff)
        pwm_art_pkg::WR_COLLECT:
          if (wr_fire)
          begin
            wr_state_ff <= pwm_art_pkg::WR_RESPOND;
            bresp_ff    <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
          end
        pwm_art_pkg::WR_RESPOND:
          if (s_axi_bready_in)
          begin
            wr_state_ff <= pwm_art_pkg::WR_COLLECT;
            aw_held_ff  <= 1'b0;
            w_held_ff   <= 1'b0;
          end
        default: wr_state_ff <= pwm_art_pkg::WR_COLLECT;
      endcase
    end
  end

  // Read channel: one cycle from address handshake to data.
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= `RESP_OKAY;
    end
    else if (ar_fire)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= {24'h000000, rd_mapped ? rd_val : `REG_RST};
      rresp_ff  <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rready_in)
      rvalid_ff <= 1'b0;
  end

  assign s_axi_awready_out = ~aw_held_ff;
  assign s_axi_wready_out  = ~w_held_ff;
  assign s_axi_bvalid_out  = (wr_state_ff == pwm_art_pkg::WR_RESPOND);
  assign s_axi_bresp_out   = bresp_ff;
  assign s_axi_arready_out = ~rvalid_ff;
  assign s_axi_rvalid_out  = rvalid_ff;
  assign s_axi_rdata_out   = rdata_ff;
  assign s_axi_rresp_out   = rresp_ff;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  chk_ovf_sets : assert property (overflow |=> overflow_flag_ff)
    else $error("overflow flag not set on wrap");
  chk_ovf_irq : assert property (overflow && overflow_irq_en_ff && !wr_csr
    |=> overflow_irq_out)
    else $error("overflow interrupt missing");
  chk_ovf_clear : assert property (rd_csr && !overflow
    |=> !overflow_flag_ff)
    else $error("status read did not clear overflow flag");
  chk_reload_value : assert property (overflow && !wr_car && !force_reload
    |=> cnt_ff == $past(auto_reload_value_ff))
    else $error("counter did not reload on wrap");
  chk_psc_kept : assert property (overflow && !wr_car && !force_reload
    |=> psc_ff == $past(psc_ff) + `PSC_ONE)
    else $error("prescaler disturbed by wrap");
  chk_stop_freeze : assert property (!counter_run_enable_ff && !wr_car
    && !force_reload |=> $stable(cnt_ff) && $stable(psc_ff))
    else $error("counter moved while stopped");
  chk_force_load : assert property (force_reload && !wr_car
    |=> cnt_ff == $past(auto_reload_value_ff) && psc_ff == `PSC_RST)
    else $error("force reload failed");
  chk_shadow_load : assert property (overflow
    |=> compare_shadow_ff == $past(duty_cycle_reg_ff))
    else $error("compare shadow not loaded on wrap");
  chk_halt_hold : assert property (halt_in ##1 halt_in
    |-> $stable(pwm_ff))
    else $error("PWM output changed during halt");

endmodule : pwm_autoreload_timer

// ==== inc/pwm_art_defs.svh ====
// Constants of the eight-bit auto-reload PWM timer: map, fields, resets.
// What this block does
// - Four hidden compares reload from duty registers at overflow.
// - Output enable bit hands pin to PWM drive.
// - PWM period is 256 minus reload counts.
// - Overflow sets each enabled output per polarity.
// - Counter passing compare restores the opposite level.
// - PWM generation stops during HALT.
// - Overflow sets flag; flag and enable request interrupt.
// - Flag marks FFh wrap; status read clears it.
// - External mode overflows after 256 minus reload prescaled events.
// - Capture edge copies counter, sets flag, enabled interrupt.
// - Edge select bit picks falling or rising.
// - Captured value kept until software reads it.
// - Capture interrupt pends while flag set and enabled.
// - Capture latches two clock edges after the event.
// - HALT blocks capture; enabled edge still wakes device.
// - Clock select bit chooses CPU or external clock.
// - Prescale field divides input by two to power.
// - Run enable low freezes prescaler and counter.
// - Force reload loads counter, clears prescaler, reads zero.
// - Counter access register reads or writes live count.
// - Counter steps per prescaled tick, reload leaves prescaler.
// - Polarity bit inverts output levels immediately.
// - Reset clears counter, prescaler, selects CPU clock.
`ifndef PWM_ART_DEFS_SVH
`define PWM_ART_DEFS_SVH

// Register indices; the byte address on the bus is four times the index.
`define IDX_DUTY3      8'h31
`define IDX_DUTY2      8'h32
`define IDX_DUTY1      8'h33
`define IDX_DUTY0      8'h34
`define IDX_PWM_OUTPUT_CONTROL      8'h35
`define IDX_CSR        8'h36
`define IDX_CAR        8'h37
`define IDX_ARR        8'h38
`define IDX_ICCSR      8'h39
`define IDX_ICR1       8'h3a
`define IDX_ICR2       8'h3b

// Bus geometry.
`define AXI_ADDR_W     12
`define AXI_DATA_W     32
`define ADDR_IDX_HI    9
`define ADDR_IDX_LO    2
`define ADDR_TOP_HI    11
`define ADDR_TOP_LO    10
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10

// Control/status field positions.
`define CSR_EXT_CLK_SELECT       7
`define CSR_CC_HI      6
`define CSR_CC_LO      4
`define CSR_TCE        3
`define CSR_FORCE_RELOAD       2
`define CSR_OIE        1
`define CSR_OVF        0

// PWM control and capture control field positions.
`define PWM_OUTPUT_CONTROL_OE_LO    4
`define ICC_CS_LO      4
`define ICC_CIE_LO     2
`define ICC_CF_LO      0

// Sizes, limits and reset values.
`define NUM_PWM        4
`define NUM_CAP        2
`define PSC_W          7
`define CNT_MAX        8'hff
`define REG_RST        8'h00
`define PSC_RST        7'h00
`define PSC_ONE        7'h01
`define CNT_ONE        8'h01

`endif

// ==== inc/pwm_art_pkg.sv ====
// Types shared by the auto-reload PWM timer modules.
package pwm_art_pkg;

  // One eight-bit register value.
  typedef logic [7:0] reg8_t;

  // Prescaler input source.
  typedef enum logic {CLK_SRC_CPU, CLK_SRC_EXT} clk_src_t;

  // Write side of the register bus slave.
  typedef enum logic [1:0] {WR_COLLECT, WR_RESPOND} wr_state_t;

endpackage : pwm_art_pkg

// ==== inc/capture_if.sv ====
// Signals between the timer core and one input capture channel.
interface capture_if;
  logic                  pin;
  logic                  edge_sel;
  logic                  irq_en;
  logic                  halt;
  pwm_art_pkg::reg8_t    count;
  logic                  rd_clear;
  logic                  flag;
  pwm_art_pkg::reg8_t    value;
  logic                  irq;
  logic                  wake;

  modport core (output pin, output edge_sel, output irq_en, output halt,
                output count, output rd_clear, input flag, input value,
                input irq, input wake);
  modport chan (input pin, input edge_sel, input irq_en, input halt,
                input count, input rd_clear, output flag, output value,
                output irq, output wake);
endinterface : capture_if

// ==== hw/capture_channel.sv ====
// One input capture channel with edge select and HALT wake-up.
`include "pwm_art_defs.svh"
module capture_channel
(
  input  wire logic  clk_in,
  input  wire logic  srst_in,
  capture_if.chan    cap
);

  logic               pin_ff;
  logic               det_ff;
  logic               flag_ff;
  pwm_art_pkg::reg8_t value_ff;
  logic               edge_now;
  logic               load;

  // Edge seen between the pin and its sampled copy; reused for wake-up.
  assign edge_now = cap.edge_sel ? (cap.pin & ~pin_ff)
                                 : (~cap.pin & pin_ff);
  // A capture never overwrites an unread value and never runs in HALT.
  assign load = det_ff & ~flag_ff & ~cap.halt;

  // Edge detected at the first clock edge, value latched at the second.
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      pin_ff   <= 1'b0;
      det_ff   <= 1'b0;
      flag_ff  <= 1'b0;
      value_ff <= `REG_RST;
    end
    else
    begin
      pin_ff   <= cap.pin;
      det_ff   <= edge_now;
      flag_ff  <= det_ff | (flag_ff & ~cap.rd_clear);
      if (load)
        value_ff <= cap.count;
    end
  end

  assign cap.flag  = flag_ff;
  assign cap.value = value_ff;
  // Pending as long as flagged and enabled, so software must read it.
  assign cap.irq   = flag_ff & cap.irq_en;
  // In HALT the wake request comes straight from the pin edge.
  assign cap.wake  = cap.halt & cap.irq_en & edge_now;

  chk_cap_hold : assert property (@(posedge clk_in) disable iff (srst_in)
    flag_ff && !cap.rd_clear |=> $stable(value_ff))
    else $error("capture value overwritten before read");

  chk_cap_latch : assert property (@(posedge clk_in) disable iff (srst_in)
    edge_now && !flag_ff && !cap.halt && !cap.rd_clear
      |=> ##1 value_ff == $past(cap.count))
    else $error("capture not latched two edges after event");

endmodule : capture_channel

// ==== sim/pin_model.sv ====
// Board-side sources: event clock and capture pins.
module pin_model
(
  input  wire logic       clk_in,
  output logic            ext_clk_out,
  output logic [1:0]      cap_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial ext_clk_out = 1'b0;
  initial cap_out = 2'b00;
  // Two cycles high, one low, so that the timer never sees two events merge.
  task pulse(input int n);
    repeat (n)
    begin
      @(posedge clk_in);
      ext_clk_out <= 1'b1;
      repeat (2) @(posedge clk_in);
      ext_clk_out <= 1'b0;
    end
    @(posedge clk_in);
  endtask : pulse
  task set_cap(input logic [1:0] v);
    @(posedge clk_in);
    cap_out <= v;
  endtask : set_cap
endmodule : pin_model

// ==== sim/tb.sv ====
// Self-checking bench for the auto-reload PWM timer.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, srst_in = 1, halt_in = 0, ext_clk_in;
  logic [11:0] s_axi_awaddr_in = 0, s_axi_araddr_in = 0;
  logic [31:0] s_axi_wdata_in = 0, s_axi_rdata_out, d;
  logic [3:0] s_axi_wstrb_in = 4'hf, pwm_out_out, pwm_out_en_n_out, sv;
  logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0;
  logic s_axi_arvalid_in = 0, s_axi_rready_in = 0, s_axi_awready_out;
  logic s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic s_axi_rvalid_out, overflow_irq_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, r, capture_input_in;
  logic [1:0] capture_irq_out, capture_wake_out;
  logic [7:0] lfsr = 8'h2b, a, dv [4];
  int n_mismatch = 0, compares = 0, h [4];
  pwm_autoreload_timer dut_u (.*);
  pin_model pm_u (.clk_in(clk_in), .ext_clk_out(ext_clk_in),
                  .cap_out(capture_input_in));
  // The clock toggles every 2 ns.
  always #2 clk_in = ~clk_in;
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : nxt
  // Steady high cycles of one channel over a 256-count period.
  function automatic int hi_cnt(input logic [7:0] dc, input logic p);
    return p ? 255 - dc : dc + 1;
  endfunction : hi_cnt
  task check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check
  task stop_test;
    $display("mismatches %0d, compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test
  // Address and data are offered together and each dropped once taken.
  task wr(input logic [11:0] ad, input logic [7:0] dt);
    @(posedge clk_in);
    s_axi_awaddr_in <= ad;
    s_axi_wdata_in <= {24'h0, dt};
    s_axi_awvalid_in <= 1;
    s_axi_wvalid_in <= 1;
    s_axi_bready_in <= 1;
    do
    begin
      @(posedge clk_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 0;
    end
    while (!s_axi_bvalid_out);
    r = s_axi_bresp_out;
    s_axi_bready_in <= 0;
  endtask : wr
  task rd(input logic [11:0] ad);
    @(posedge clk_in);
    s_axi_araddr_in <= ad;
    s_axi_arvalid_in <= 1;
    s_axi_rready_in <= 1;
    do
    begin
      @(posedge clk_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 0;
    end
    while (!s_axi_rvalid_out);
    d = s_axi_rdata_out;
    r = s_axi_rresp_out;
    s_axi_rready_in <= 0;
  endtask : rd
  // Registers, event counting, PWM, HALT and capture in turn.
  initial
  begin
    repeat (10) @(posedge clk_in);
    srst_in <= 0;
    for (int i = 0; i < 4; i++)
    begin
      rd(12'hd4 + 12'(4 * i));
      check(d, 0);
    end
    rd(12'hf0);
    check(r, 2'b10);
    lfsr = nxt(lfsr);
    a = {6'h3c, lfsr[1:0]};
    wr(12'he0, a);
    check(r, 2'b00);
    wr(12'hf0, 8'h55);
    check(r, 2'b10);
    wr(12'hd8, 8'h04);
    rd(12'hdc);
    check(d, a);
    rd(12'hd8);
    check(d, 0);
    for (int c = 0; c < 3; c++)
    begin
      wr(12'hd8, 8'h8e | 8'(c << 4));
      pm_u.pulse(((256 - a) << c) - 1);
      repeat (4) @(posedge clk_in);
      check(overflow_irq_out, 0);
      pm_u.pulse(1);
      repeat (4) @(posedge clk_in);
      check(overflow_irq_out, 1);
      rd(12'hd8);
      check(d, 8'h8b | 8'(c << 4));
      check(overflow_irq_out, 0);
    end
    wr(12'he0, 8'h00);
    for (int c = 0; c < 4; c++)
    begin
      lfsr = nxt(lfsr);
      dv[c] = lfsr;
      wr(12'hd0 - 12'(4 * c), lfsr);
    end
    wr(12'hd8, 8'h0c);
    for (int p = 0; p < 2; p++)
    begin
      wr(12'hd4, p ? 8'hff : 8'hf0);
      repeat (600) @(posedge clk_in);
      h = '{default: 0};
      repeat (256)
      begin
        @(posedge clk_in);
        foreach (h[c]) h[c] += int'(pwm_out_out[c] === 1'b1);
      end
      check(pwm_out_en_n_out, 0);
      foreach (h[c])
        check(h[c], hi_cnt(dv[c], p[0]));
    end
    halt_in <= 1;
    repeat (3) @(posedge clk_in);
    sv = pwm_out_out;
    repeat (100) @(posedge clk_in);
    check(pwm_out_out, sv);
    halt_in <= 0;
    wr(12'hd8, 8'h00);
    wr(12'he4, 8'h14);
    rd(12'hdc);
    a = d[7:0];
    pm_u.set_cap(2'b01);
    repeat (4) @(posedge clk_in);
    check(capture_irq_out, 2'b01);
    rd(12'he8);
    check(d, a);
    check(capture_irq_out, 2'b00);
    pm_u.set_cap(2'b00);
    halt_in <= 1;
    pm_u.set_cap(2'b01);
    #1;
    check(capture_wake_out, 2'b01);
    stop_test;
  end
  // A hang is cut short well past the expected run length.
  initial
  begin
    repeat (30000) @(posedge clk_in);
    n_mismatch++;
    stop_test;
  end
endmodule : tb
